// ===== bench/ptc_exec_model.sv
// Scan executor model: one request at a time, answer collected on ack
`timescale 1ns/1ns
module ptc_exec_model (
    input  wire logic              clk_i,
    input  wire logic              op_ready_i,
    input  wire logic              ack_i,
    input  wire ptc_pkg::ptc_ans_t ans_i,
    output logic                   op_valid_o,
    output ptc_pkg::ptc_req_t      op_o
);
    // Idle at time zero
    initial begin
        op_valid_o = 1'b0;
        op_o       = '0;
    end
    // Hold the request until ready is seen, release, then wait for ack
    task automatic run(input ptc_pkg::ptc_req_t r, output ptc_pkg::ptc_ans_t a,
                       output logic ok);
        int n;
        n = 0;
        @(negedge clk_i);
        op_valid_o = 1'b1;
        op_o       = r;
        while (op_ready_i !== 1'b1 && n < 400) begin
            n++;
            @(negedge clk_i);
        end
        @(negedge clk_i);
        op_valid_o = 1'b0;
        op_o       = ~r;  // Released word never shows the old value
        while (ack_i !== 1'b1 && n < 400) begin
            n++;
            @(negedge clk_i);
        end
        a  = ans_i;
        ok = (n < 400);
    endtask
endmodule // ptc_exec_model

// ===== bench/testbench.sv
// Self-checking bench of the timer and counter bank
`timescale 1ns/1ns
module testbench;
    localparam int TICK = 600;  // Short 4.8 us finest base (600 cycles) keeps the run brief
    logic              clk = 1'b0;
    logic              arst_n = 1'b0;
    logic              op_valid;
    ptc_pkg::ptc_req_t op;
    logic              op_ready;
    logic              ack;
    ptc_pkg::ptc_ans_t ans;
    ptc_pkg::ptc_ans_t a;               // Last answer
    logic              ok;              // Handshake done in time
    logic [15:0]       seed = 16'h0012; // Fixed seed
    int                v;
    int                n_fail = 0;
    int                checks_done = 0;
    // 125 MHz clock
    always #4 clk = ~clk;
    ptc_bank #(.TICK_CYC(TICK)) u_ptc_bank (.clk_i(clk), .arst_n_i(arst_n),
        .op_valid_i(op_valid), .op_i(op), .op_ready_o(op_ready), .ack_o(ack), .ans_o(ans));
    ptc_exec_model u_ptc_exec_model (.clk_i(clk), .op_ready_i(op_ready), .ack_i(ack),
        .ans_i(ans), .op_valid_o(op_valid), .op_o(op));
    // Next pseudo-random word
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Decimal to three BCD digits
    function automatic logic [15:0] bcd(input int x);
        return {4'h0, 4'(x / 100), 4'(x / 10 % 10), 4'(x % 10)};
    endfunction
    // Compare and count
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One request through the executor model
    task automatic go(input ptc_pkg::ptc_op_t c, input int i, input logic r,
                      input logic [15:0] w);
        u_ptc_exec_model.run({c, 7'(i), r, w}, a, ok);
        chk("handshake", 16'(ok), 16'h0001);
    endtask
    // Low then high input, so the second request sees a rising edge
    task automatic rise(input ptc_pkg::ptc_op_t c, input int i, input logic [15:0] w);
        go(c, i, 1'b0, w);
        go(c, i, 1'b1, w);
    endtask
    // Counts, then verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Cuts a hang short
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        // Load with junk in the top nibble, then saturate upward
        rise(ptc_pkg::PTC_C_SET, 5, 16'hf998);
        chk("cnt load", a.bin, 16'h03e6);
        rise(ptc_pkg::PTC_C_UP, 5, 16'h0000);
        rise(ptc_pkg::PTC_C_UP, 5, 16'h0000);
        chk("cnt top", a.bcd, 16'h0999);
        go(ptc_pkg::PTC_C_RESET, 5, 1'b1, 16'h0000);
        chk("cnt clear", a.bin, 16'h0000);
        rise(ptc_pkg::PTC_C_DN, 5, 16'h0000);
        chk("cnt floor", 16'(a.status), 16'h0000);
        // Random loads and one count down, index 127 first
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            v = int'(seed) % 1000;
            rise(ptc_pkg::PTC_C_SET, k ? int'(seed[6:0]) : 127, bcd(v) | {seed[15:12], 12'h000});
            rise(ptc_pkg::PTC_C_DN, k ? int'(seed[6:0]) : 127, seed);
            chk("cnt down", a.bin, 16'(v ? v - 1 : 0));
            go(ptc_pkg::PTC_C_SCAN, k ? int'(seed[6:0]) : 127, 1'b0, seed);
            chk("cnt bcd", a.bcd, bcd(v ? v - 1 : 0));
            chk("cnt stat", 16'(a.status), 16'(v > 1));
        end
        // Finest base, value 2, top bits set
        rise(ptc_pkg::PTC_T_PULSE, 1, 16'hc002);
        chk("pulse run", {a.status, a.bin[14:0]}, 16'h8002);
        go(ptc_pkg::PTC_T_PULSE, 1, 1'b0, 16'hc002);
        chk("pulse clr", 16'(a.status), 16'h0000);
        rise(ptc_pkg::PTC_T_EXT, 2, 16'hc002);
        go(ptc_pkg::PTC_T_EXT, 2, 1'b0, 16'hc002);
        chk("ext hold", 16'(a.status), 16'h0001);
        rise(ptc_pkg::PTC_T_ONDLY, 3, 16'hc002);
        chk("ondly early", 16'(a.status), 16'h0000);
        rise(ptc_pkg::PTC_T_ONDLY, 8, 16'h1001);
        rise(ptc_pkg::PTC_T_LATCH, 4, 16'hc002);
        go(ptc_pkg::PTC_T_LATCH, 4, 1'b0, 16'hc002);
        go(ptc_pkg::PTC_T_OFFDLY, 6, 1'b1, 16'h0002);
        chk("off high", 16'(a.status), 16'h0001);
        go(ptc_pkg::PTC_T_OFFDLY, 6, 1'b0, 16'h0002);
        chk("off run", 16'(a.status), 16'h0001);
        rise(ptc_pkg::PTC_T_EXT, 7, 16'h0005);
        repeat (1000) @(negedge clk);
        go(ptc_pkg::PTC_T_EXT, 7, 1'b0, 16'h0005);
        chk("ext tick", 16'(a.bin < 16'h0005), 16'h0001);
        go(ptc_pkg::PTC_T_EXT, 7, 1'b1, 16'h0005);
        chk("ext restart", a.bin, 16'h0005);
        repeat (2000) @(negedge clk);
        go(ptc_pkg::PTC_T_SCAN, 2, 1'b0, 16'h0000);
        chk("ext end", 16'(a.status), 16'h0000);
        go(ptc_pkg::PTC_T_SCAN, 3, 1'b0, 16'h0000);
        chk("ondly out", {a.status, a.bin[14:0]}, 16'h8000);
        go(ptc_pkg::PTC_T_SCAN, 8, 1'b0, 16'h0000);
        chk("base1 early", 16'(a.status), 16'h0000);
        go(ptc_pkg::PTC_T_SCAN, 4, 1'b0, 16'h0000);
        chk("latch out", 16'(a.status), 16'h0001);
        go(ptc_pkg::PTC_T_RESET, 4, 1'b1, 16'h0000);
        chk("latch rst", {a.status, a.bcd[14:0]}, 16'h0002);
        go(ptc_pkg::PTC_T_SCAN, 6, 1'b0, 16'h0000);
        chk("off end", 16'(a.status), 16'h0000);
        repeat (5000) @(negedge clk);
        go(ptc_pkg::PTC_T_SCAN, 8, 1'b0, 16'h0000);
        chk("base1 out", 16'(a.status), 16'h0001);
        summarize();
    end
endmodule // testbench

// ===== hw/ptc_bank.sv
// Scan-driven timer and counter bank with free-running time bases
`timescale 1ns/1ns
module ptc_bank #(
    parameter int TICK_CYC = ptc_pkg::BASE0_CYC  // Cycles per 0.01 s tick
) (
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              op_valid_i,
    input  wire ptc_pkg::ptc_req_t op_i,
    output logic                   op_ready_o,
    output logic                   ack_o,
    output ptc_pkg::ptc_ans_t      ans_o
);

    ptc_pkg::ptc_state_t st_ff;    // Registered state
    ptc_pkg::ptc_state_t nxt_st;   // Next state

    // Memory ports
    logic                       t_we;
    logic                       c_we;
    logic [ptc_pkg::IDX_W-1:0]  waddr;
    logic [ptc_pkg::IDX_W-1:0]  raddr;
    ptc_pkg::ptc_tmr_t          t_wd;
    ptc_pkg::ptc_tmr_t          t_rd;
    ptc_pkg::ptc_cnt_t          c_wd;
    ptc_pkg::ptc_cnt_t          c_rd;

    // Timer entries, one per timer number
    ptc_mem #(
        .W  ($bits(ptc_pkg::ptc_tmr_t)),
        .D  (ptc_pkg::N_TIMERS),
        .AW (ptc_pkg::IDX_W)
    ) u_tmr_mem (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .we_i     (t_we),
        .waddr_i  (waddr),
        .wdata_i  (t_wd),
        .raddr_i  (raddr),
        .rdata_o  (t_rd)
    );

    // Counter entries, one per counter number
    ptc_mem #(
        .W  ($bits(ptc_pkg::ptc_cnt_t)),
        .D  (ptc_pkg::N_COUNTERS),
        .AW (ptc_pkg::IDX_W)
    ) u_cnt_mem (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .we_i     (c_we),
        .waddr_i  (waddr),
        .wdata_i  (c_wd),
        .raddr_i  (raddr),
        .rdata_o  (c_rd)
    );

    // Sequencer, divider and per-entry operation logic
    always_comb begin
        ptc_pkg::ptc_tmr_t te;     // Updated timer entry
        ptc_pkg::ptc_cnt_t ce;     // Updated counter entry
        ptc_pkg::ptc_req_t q;      // Request being executed
        logic              tick;   // 0.01 s pulse
        logic              carry;  // Decade carry into coarser base
        logic              rise;   // Rising edge of the timer input
        logic              fall;   // Falling edge of the timer input
        nxt_st = st_ff;
        te     = t_rd;
        ce     = c_rd;
        q      = st_ff.op;
        t_we   = 1'b0;
        c_we   = 1'b0;
        waddr  = st_ff.is_op ? q.idx : st_ff.ptr;
        raddr  = st_ff.ptr;
        t_wd   = t_rd;
        c_wd   = c_rd;
        rise   = q.lrb & ~t_rd.last_lrb;
        fall   = ~q.lrb & t_rd.last_lrb;
        nxt_st.ack = 1'b0;

        // Time bases run regardless of requests
        tick = (st_ff.div == ptc_pkg::DIV_W'(TICK_CYC - 1));
        nxt_st.div = tick ? '0 : st_ff.div + 1'b1;
        carry = tick;
        if (tick) begin
            nxt_st.phase[0] = ~st_ff.phase[0];
        end
        for (int b = 1; b < ptc_pkg::N_BASES; b++) begin
            if (carry) begin
                if (st_ff.dec[b-1] == 4'(ptc_pkg::BASE_STEP - 1)) begin
                    nxt_st.dec[b-1]  = 4'h0;
                    nxt_st.phase[b] = ~st_ff.phase[b];
                end else begin
                    nxt_st.dec[b-1] = st_ff.dec[b-1] + 4'h1;
                    carry = 1'b0;
                end
            end
        end

        unique case (st_ff.fsm)
            // Clear every entry once after reset
            ptc_pkg::PTC_INIT: begin
                t_we  = 1'b1;
                c_we  = 1'b1;
                waddr = st_ff.ptr;
                t_wd  = '0;
                c_wd  = '0;
                nxt_st.ptr = st_ff.ptr + 1'b1;
                if (st_ff.ptr == '1) begin
                    nxt_st.fsm = ptc_pkg::PTC_ISSUE;
                end
            end
            // A request beats the sweep for the read slot
            ptc_pkg::PTC_ISSUE: begin
                nxt_st.fsm = ptc_pkg::PTC_EXEC;
                if (op_valid_i && st_ff.ready) begin
                    nxt_st.op    = op_i;
                    nxt_st.is_op = 1'b1;
                    raddr        = op_i.idx;
                end else begin
                    nxt_st.is_op = 1'b0;
                end
            end
            // Entry data are valid now: compute and write back
            ptc_pkg::PTC_EXEC: begin
                nxt_st.fsm = ptc_pkg::PTC_ISSUE;
                if (!st_ff.is_op) begin
                    // Background countdown, one entry per two cycles
                    if (t_rd.running && t_rd.phase != st_ff.phase[t_rd.base]) begin
                        te.phase = ~t_rd.phase;
                        if (t_rd.cnt <= 10'h001) begin
                            te.cnt     = ptc_pkg::CNT_ZERO;
                            te.running = 1'b0;
                            te.done    = 1'b1;
                        end else begin
                            te.cnt = t_rd.cnt - 10'h001;
                        end
                    end
                    t_we = 1'b1;
                    nxt_st.ptr = st_ff.ptr + 1'b1;
                end else if (q.code[3] == 1'b0) begin
                    unique case (q.code)
                        ptc_pkg::PTC_T_PULSE, ptc_pkg::PTC_T_ONDLY: begin
                            te.last_lrb = q.lrb;
                            if (!q.lrb) begin
                                te.running = 1'b0;
                                te.done    = 1'b0;
                                te.cnt     = ptc_pkg::CNT_ZERO;
                            end
                        end
                        ptc_pkg::PTC_T_EXT, ptc_pkg::PTC_T_LATCH: begin
                            te.last_lrb = q.lrb;
                        end
                        ptc_pkg::PTC_T_OFFDLY: begin
                            te.last_lrb = q.lrb;
                            if (q.lrb) begin
                                te.mode    = q.code;
                                te.init    = q.word[ptc_pkg::VAL_MSB:ptc_pkg::VAL_LSB];
                                te.base    = q.word[ptc_pkg::BASE_MSB:ptc_pkg::BASE_LSB];
                                te.cnt     = ptc_pkg::bcd_to_bin(te.init);
                                te.running = 1'b0;
                                te.done    = 1'b0;
                            end
                        end
                        ptc_pkg::PTC_T_RESET: begin
                            if (q.lrb) begin
                                te.cnt     = ptc_pkg::bcd_to_bin(t_rd.init);
                                te.running = 1'b0;
                                te.done    = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                    // Start on the qualifying edge, also while running
                    if ((rise && q.code inside {ptc_pkg::PTC_T_PULSE, ptc_pkg::PTC_T_EXT,
                            ptc_pkg::PTC_T_ONDLY, ptc_pkg::PTC_T_LATCH}) ||
                        (fall && q.code == ptc_pkg::PTC_T_OFFDLY)) begin
                        te.mode    = q.code;
                        te.init    = q.word[ptc_pkg::VAL_MSB:ptc_pkg::VAL_LSB];
                        te.base    = q.word[ptc_pkg::BASE_MSB:ptc_pkg::BASE_LSB];
                        te.cnt     = ptc_pkg::bcd_to_bin(te.init);
                        te.running = 1'b1;
                        te.done    = 1'b0;
                        te.phase   = st_ff.phase[te.base];
                    end
                    t_we = 1'b1;
                    nxt_st.ack        = 1'b1;
                    nxt_st.ans.status = ptc_pkg::tmr_status(te);
                    nxt_st.ans.bin    = 16'(te.cnt);
                    nxt_st.ans.bcd    = 16'(ptc_pkg::bin_to_bcd(te.cnt));
                end else begin
                    // Counter operations, set, up and down inputs each with their own edge memory; reset acts on level
                    unique case (q.code)
                        ptc_pkg::PTC_C_SET: begin
                            ce.e_set = q.lrb;
                            if (q.lrb && !c_rd.e_set) begin
                                ce.cnt = ptc_pkg::bcd_to_bin(q.word[11:0]);
                            end
                        end
                        ptc_pkg::PTC_C_RESET: begin
                            if (q.lrb) begin
                                ce.cnt = ptc_pkg::CNT_ZERO;
                            end
                        end
                        ptc_pkg::PTC_C_UP: begin
                            ce.e_up = q.lrb;
                            if (q.lrb && !c_rd.e_up && c_rd.cnt != ptc_pkg::CNT_MAX) begin
                                ce.cnt = c_rd.cnt + 10'h001;
                            end
                        end
                        ptc_pkg::PTC_C_DN: begin
                            ce.e_dn = q.lrb;
                            if (q.lrb && !c_rd.e_dn && c_rd.cnt != ptc_pkg::CNT_ZERO) begin
                                ce.cnt = c_rd.cnt - 10'h001;
                            end
                        end
                        default: begin
                        end
                    endcase
                    c_we = 1'b1;
                    c_wd = ce;
                    nxt_st.ack        = 1'b1;
                    nxt_st.ans.status = (ce.cnt != ptc_pkg::CNT_ZERO);
                    nxt_st.ans.bin    = 16'(ce.cnt);
                    nxt_st.ans.bcd    = 16'(ptc_pkg::bin_to_bcd(ce.cnt));
                end
                if (st_ff.fsm == ptc_pkg::PTC_EXEC) begin
                    t_wd = te;
                end
            end
            default: begin
                nxt_st.fsm = ptc_pkg::PTC_INIT;  // Code 2'b10 is illegal
            end
        endcase
        nxt_st.ready = (nxt_st.fsm == ptc_pkg::PTC_ISSUE);
    end

    // State register; memories hold nothing valid until init ends
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign op_ready_o = st_ff.ready;
    assign ack_o      = st_ff.ack;
    assign ans_o      = st_ff.ans;

    // Checks, all in the system clock domain
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    ack_after_op_a: assert property (ack_o |-> $past(st_ff.fsm) == ptc_pkg::PTC_EXEC
        && $past(st_ff.is_op) && !$past(ack_o))
        else $error("answer without an executed request");
    ready_spacing_a: assert property (op_ready_o && op_valid_i |=> !op_ready_o ##1 ack_o)
        else $error("accepted request not answered two cycles later");
    cnt_range_a: assert property (ack_o && st_ff.op.code[3] |-> ans_o.bin <= 16'h03e7)
        else $error("count above 999");
    cnt_status_a: assert property (ack_o && st_ff.op.code[3] |->
        ans_o.status == (ans_o.bin != 16'h0000))
        else $error("counter status does not match count");
    cnt_reset_a: assert property (ack_o && st_ff.op.code == ptc_pkg::PTC_C_RESET
        && st_ff.op.lrb |-> ans_o.bin == 16'h0000)
        else $error("counter reset left a nonzero count");
    pulse_clear_a: assert property (ack_o && st_ff.op.code == ptc_pkg::PTC_T_PULSE
        && !st_ff.op.lrb |-> !ans_o.status && ans_o.bin == 16'h0000)
        else $error("pulse timer not cleared by zero input");
    // Entry mode is taken from the execute cycle, where the write data hold that entry
    tmr_reset_a: assert property (ack_o && st_ff.op.code == ptc_pkg::PTC_T_RESET
        && st_ff.op.lrb && $past(t_wd.mode) != ptc_pkg::PTC_T_OFFDLY |-> !ans_o.status)
        else $error("timer reset left status set");
    offdly_hold_a: assert property (ack_o && st_ff.op.code == ptc_pkg::PTC_T_OFFDLY
        && st_ff.op.lrb |-> ans_o.status
        && ans_o.bin == 16'(ptc_pkg::bcd_to_bin(st_ff.op.word[11:0])))
        else $error("off-delay not held at initial value");
    bcd_match_a: assert property (ack_o |->
        ans_o.bcd == 16'(ptc_pkg::bin_to_bcd(ans_o.bin[9:0])))
        else $error("BCD and binary values disagree");
    cnt_sat_a: assert property (ack_o && st_ff.op.code == ptc_pkg::PTC_C_UP
        && $past(c_rd.cnt) == ptc_pkg::CNT_MAX |-> ans_o.bin == 16'h03e7)
        else $error("count wrapped past 999");
    tick_toggle_a: assert property ($changed(st_ff.phase[1]) |-> $changed(st_ff.phase[0]))
        else $error("coarse base ticked without a fine tick");

    pulse_run_c: cover property (ack_o && st_ff.op.code == ptc_pkg::PTC_T_PULSE && ans_o.status);
    expire_c:    cover property (st_ff.fsm == ptc_pkg::PTC_EXEC && !st_ff.is_op && t_we
        && t_rd.running && !t_wd.running);
    cnt_full_c:  cover property (ack_o && ans_o.bin == 16'h03e7);
    latch_c:     cover property (ack_o && st_ff.op.code == ptc_pkg::PTC_T_LATCH && ans_o.status);

endmodule // ptc_bank

// ===== hw/ptc_mem.sv
// Entry memory of the bank: one write port, one registered read port
`timescale 1ns/1ns
module ptc_mem #(
    parameter int W  = 32,
    parameter int D  = 128,
    parameter int AW = 7
) (
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [W-1:0]  wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [W-1:0]  rdata_o
);

    logic [W-1:0] mem_ff [D];  // Array, cleared by the owner after reset

    // Write port, no reset so it maps to RAM
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_ff[waddr_i] <= wdata_i;
        end
    end

    // Registered read, old data on a same-cycle write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_ff[raddr_i];
        end
    end

endmodule // ptc_mem

// ===== hw/ptc_pkg.sv
// Shared constants, types and BCD helpers of the scan timer/counter bank
package ptc_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS   = 8;           // 125 MHz system clock
    localparam int BASE0_PERIOD_NS = 10_000_000;  // Finest time base, 0.01 s
    localparam int BASE0_CYC       = BASE0_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BASE_STEP       = 10;          // Each coarser base is ten times slower
    localparam int N_BASES         = 4;           // 0.01 s, 0.1 s, 1 s, 10 s
    localparam int DIV_W           = $clog2(BASE0_CYC);

    // Bank geometry
    localparam int N_TIMERS   = 128;
    localparam int N_COUNTERS = 128;
    localparam int IDX_W      = 7;

    // Time word and count word layout
    localparam int VAL_LSB   = 0;                 // Three BCD digits, bits 0..11
    localparam int VAL_MSB   = 11;
    localparam int BASE_LSB  = 12;                // Time base code, bits 12..13
    localparam int BASE_MSB  = 13;

    // Count range
    localparam logic [9:0] CNT_MAX  = 10'h3e7;    // 999
    localparam logic [9:0] CNT_ZERO = 10'h000;

    // Operations issued by the scan executor
    typedef enum logic [3:0] {
        PTC_T_PULSE  = 4'h0,  // impulse_timer_op
        PTC_T_EXT    = 4'h1,  // stretch_timing_op
        PTC_T_ONDLY  = 4'h2,  // on_delay_op
        PTC_T_LATCH  = 4'h3,  // latched_on_delay_op
        PTC_T_OFFDLY = 4'h4,  // off_delay_op
        PTC_T_RESET  = 4'h5,  // Timer reset
        PTC_T_SCAN   = 4'h6,  // Timer status and value read
        PTC_C_SET    = 4'h8,  // Counter load
        PTC_C_RESET  = 4'h9,  // Counter reset
        PTC_C_UP     = 4'ha,  // increment_op
        PTC_C_DN     = 4'hb,  // decrement_op
        PTC_C_SCAN   = 4'hc   // Counter status and value read
    } ptc_op_t;

    // Sequencer states, Gray along init -> issue <-> exec
    typedef enum logic [1:0] {
        PTC_INIT  = 2'b00,
        PTC_ISSUE = 2'b01,
        PTC_EXEC  = 2'b11
    } ptc_fsm_t;

    // One request from the executor
    typedef struct packed {
        ptc_op_t            code;  // Operation
        logic [IDX_W-1:0]   idx;   // Timer or counter number
        logic               lrb;   // logic_result_bit
        logic [15:0]        word;  // first_working_register
    } ptc_req_t;

    // One answer to the executor
    typedef struct packed {
        logic        status;  // Scan result
        logic [15:0] bin;     // Current value, binary
        logic [15:0] bcd;     // Current value, BCD
    } ptc_ans_t;

    // Stored timer entry, 32 bits
    typedef struct packed {
        ptc_op_t     mode;      // Last start mode
        logic        last_lrb;  // Edge memory of the start input
        logic        running;   // Counting down
        logic        done;      // Ran out
        logic        phase;     // Last seen toggle of its base
        logic [1:0]  base;      // Time base code
        logic [11:0] init;      // Initial value, BCD
        logic [9:0]  cnt;       // Remaining value, binary
    } ptc_tmr_t;

    // Stored counter entry, one edge memory per counting input
    typedef struct packed {
        logic [9:0] cnt;
        logic       e_set;
        logic       e_up;
        logic       e_dn;
    } ptc_cnt_t;

    // Whole sequencer state
    typedef struct packed {
        ptc_fsm_t                     fsm;
        logic                         ready;
        logic                         ack;
        ptc_ans_t                     ans;
        ptc_req_t                     op;
        logic                         is_op;
        logic [IDX_W-1:0]             ptr;
        logic [DIV_W-1:0]             div;
        logic [N_BASES-2:0][3:0]      dec;
        logic [N_BASES-1:0]           phase;
    } ptc_state_t;

    // Three BCD digits to binary, sums above 999 clamp at 999
    function automatic logic [9:0] bcd_to_bin(input logic [11:0] b);
        logic [13:0] s;
        s = 14'(b[11:8]) * 14'h0064 + 14'(b[7:4]) * 14'h000a + 14'(b[3:0]);
        if (s > 14'(CNT_MAX)) begin
            s = 14'(CNT_MAX);
        end
        return s[9:0];
    endfunction

    // Binary to three BCD digits by shift and add three
    function automatic logic [11:0] bin_to_bcd(input logic [9:0] v);
        logic [21:0] sh;
        sh = {12'h000, v};
        for (int i = 0; i < 10; i++) begin
            for (int d = 0; d < 3; d++) begin
                if (sh[10+4*d +: 4] >= 4'h5) begin
                    sh[10+4*d +: 4] = sh[10+4*d +: 4] + 4'h3;
                end
            end
            sh = sh << 1;
        end
        return sh[21:10];
    endfunction

    // Scan result of a timer entry, by the mode it was started in
    function automatic logic tmr_status(input ptc_tmr_t e);
        case (e.mode)
            PTC_T_PULSE, PTC_T_EXT: return e.running;
            PTC_T_ONDLY:            return e.done & e.last_lrb;
            PTC_T_LATCH:            return e.done;
            PTC_T_OFFDLY:           return e.last_lrb | e.running;
            default:                return 1'b0;
        endcase
    endfunction

endpackage
